// ---- verilog/mem_drive_consts.svh ----
// Constants for the buffer memory address and byte-mask drive.
// Assumes one memory clock, pins sampled by the memory on its rising edge.
`ifndef MEM_DRIVE_CONSTS_SVH
`define MEM_DRIVE_CONSTS_SVH
`define ADDR_PINS 12
`define ROW_BITS 12
`define COL_BITS 11
`define COL_LOW_BITS 10
`define AP_LINE 10
`define DATA_BITS 32
`define LANES 4
`define FIFO_DEPTH 4
`define IDLE_ADDR 12'h000
`define IDLE_MASK 4'h0
`endif

// ---- verilog/mem_drive_pkg.sv ----
// Types for the buffer memory address and byte-mask drive.
// Assumes the constants header is present on the include path.
package mem_drive_pkg;
  // Gray coded along idle -> row -> col; col -> idle changes both bits
  typedef enum logic [1:0] {
    ph_idle = 2'b00,
    ph_row = 2'b01,
    ph_col = 2'b11
  } phase_t;
endpackage

// ---- verilog/req_fifo.sv ----
// Small request FIFO with valid/ready on both sides.
// Assumes a single clock and asynchronous active-high reset.
`timescale 1ns/1ps
module req_fifo #(
  parameter int WIDTH = 58,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("req_fifo DEPTH must be a power of two of at least 2");
  end
  typedef struct packed {
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } fifo_state_t;
  fifo_state_t st_reg, st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full, empty, push, pop;
  assign empty = st_reg.wr_ptr == st_reg.rd_ptr;
  assign full = (st_reg.wr_ptr[AW-1:0] == st_reg.rd_ptr[AW-1:0]) &&
                (st_reg.wr_ptr[AW] != st_reg.rd_ptr[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;
  assign out_data = mem[st_reg.rd_ptr[AW-1:0]];
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr_ptr = st_reg.wr_ptr + {{AW{1'b0}}, 1'b1};
    end
    if (pop) begin
      st_next.rd_ptr = st_reg.rd_ptr + {{AW{1'b0}}, 1'b1};
    end
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[st_reg.wr_ptr[AW-1:0]] <= in_data;
    end
  end
  fifo_count_a: assert property (@(posedge mclk) disable iff (reset)
    push && !pop |=> !empty)
    else $error("fifo empty after push");
endmodule

// ---- verilog/mem_addr_drive.sv ----
// Drives the buffer memory address, byte-mask and write data pins.
// Assumes an upstream engine issues requests; commands and timing are elsewhere.
`include "mem_drive_consts.svh"
`timescale 1ns/1ps
module mem_addr_drive
  import mem_drive_pkg::*;
#(
  parameter int ROW_W = `ROW_BITS,
  parameter int COL_W = `COL_BITS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Request stream from the buffer engine
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [ROW_W-1:0] req_row,
  input wire logic [COL_W-1:0] req_col,
  input wire logic req_write,
  input wire logic req_auto_precharge,
  input wire logic [`LANES-1:0] req_lane_write,
  input wire logic [`DATA_BITS-1:0] req_wdata,
  // Memory pins
  output logic [`ADDR_PINS-1:0] mem_addr,
  output logic [`LANES-1:0] mem_byte_write_enable,
  output logic [`DATA_BITS-1:0] mem_data_bus_out,
  output logic mem_data_bus_oe_n,
  // Phase indicators for the command logic
  output logic row_phase,
  output logic col_phase
);
  localparam int REQ_W = ROW_W + COL_W + 2 + `LANES + `DATA_BITS;
  if (ROW_W != `ROW_BITS || COL_W != `COL_BITS) begin : g_width_check
    $error("mem_addr_drive address widths are fixed by the pin map");
  end

  if (ROW_W != `ADDR_PINS) begin : g_row_check
    $error("mem_addr_drive row must fill every address line");
  end

  if (COL_W != `COL_LOW_BITS + 1 || `AP_LINE != `COL_LOW_BITS) begin : g_col_check
    $error("mem_addr_drive column map does not fit the address lines");
  end

  if (`FIFO_DEPTH < 2) begin : g_depth_check
    $error("mem_addr_drive request buffer needs two entries or more");
  end

  typedef struct packed {
    phase_t phase;
    logic [`ADDR_PINS-1:0] addr;
    logic [`LANES-1:0] mask;
    logic [`DATA_BITS-1:0] wdata;
    logic oe_n;
    logic [COL_W-1:0] col;
    logic write;
    logic ap;
    logic [`LANES-1:0] lanes;
    logic [`DATA_BITS-1:0] data;
  } drive_state_t;

  drive_state_t st_reg, st_next;
  logic f_valid;
  logic f_ready;
  logic [REQ_W-1:0] f_data;
  logic [REQ_W-1:0] f_in;
  logic [ROW_W-1:0] f_row;
  logic [COL_W-1:0] f_col;
  logic f_write;
  logic f_ap;
  logic [`LANES-1:0] f_lanes;
  logic [`DATA_BITS-1:0] f_wdata;

  // Column word: lines 0-9 and 11 from column, line 10 auto-precharge
  function automatic logic [`ADDR_PINS-1:0] col_word(input logic [COL_W-1:0] c,
                                                      input logic ap);
    logic [`ADDR_PINS-1:0] w;
    w = '0;
    for (int i = 0; i < `COL_LOW_BITS; i++) begin
      w[i] = c[i];
    end
    w[`AP_LINE] = ap;
    w[`ADDR_PINS-1] = c[COL_W-1];
    col_word = w;
  endfunction

  // Queue word: row, column, kind, precharge, lanes, data
  assign f_in = {
    req_row,
    req_col,
    req_write,
    req_auto_precharge,
    req_lane_write,
    req_wdata
  };

  req_fifo #(
    .WIDTH(REQ_W),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(f_in),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );
  assign {f_row, f_col, f_write, f_ap, f_lanes, f_wdata} = f_data;
  assign f_ready = st_reg.phase == ph_idle;

  // Sequencer needs no configuration; starts from reset
  always_comb begin
    st_next = st_reg;
    st_next.mask = `IDLE_MASK;
    st_next.oe_n = 1'b1;
    case (st_reg.phase)
      ph_idle: begin
        if (f_valid) begin
          st_next.phase = ph_row;
          st_next.addr = f_row;
          st_next.col = f_col;
          st_next.write = f_write;
          st_next.ap = f_ap;
          st_next.lanes = f_lanes;
          st_next.data = f_wdata;
        end
      end
      ph_row: begin
        st_next.phase = ph_col;
        st_next.addr = col_word(st_reg.col, st_reg.ap);
        if (st_reg.write) begin
          // Mask and data leave together with the column
          st_next.mask = st_reg.lanes;
          st_next.wdata = st_reg.data;
          st_next.oe_n = 1'b0;
        end
      end
      ph_col: begin
        st_next.phase = ph_idle;
        st_next.addr = `IDLE_ADDR;
      end
      default: begin
        st_next.phase = ph_idle;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign mem_addr = st_reg.addr;
  // Lane i gates data bits 8i+7:8i, bit 0 lowest, bit 3 highest
  assign mem_byte_write_enable = st_reg.mask;
  assign mem_data_bus_out = st_reg.wdata;
  assign mem_data_bus_oe_n = st_reg.oe_n;
  assign row_phase = st_reg.phase == ph_row;
  assign col_phase = st_reg.phase == ph_col;

  // Access sequencing
  row_then_col_a: assert property (@(posedge mclk) disable iff (reset)
    row_phase |=> col_phase)
    else $error("column phase did not follow row phase");

  row_once_a: assert property (@(posedge mclk) disable iff (reset)
    row_phase |=> !row_phase)
    else $error("row phase held beyond one cycle");

  col_once_a: assert property (@(posedge mclk) disable iff (reset)
    col_phase |=> !col_phase)
    else $error("column phase held beyond one cycle");

  col_after_row_a: assert property (@(posedge mclk) disable iff (reset)
    col_phase |-> $past(row_phase))
    else $error("column phase without a row phase before it");

  phases_apart_a: assert property (@(posedge mclk) disable iff (reset)
    !(row_phase && col_phase))
    else $error("row and column phases together");

  phase_legal_a: assert property (@(posedge mclk) disable iff (reset)
    st_reg.phase inside {ph_idle, ph_row, ph_col})
    else $error("sequencer left its legal states");

  no_restart_a: assert property (@(posedge mclk) disable iff (reset)
    row_phase || col_phase |-> !f_ready)
    else $error("new request taken inside an access");

  idle_after_col_a: assert property (@(posedge mclk) disable iff (reset)
    col_phase |=> !row_phase && !col_phase && mem_addr == `IDLE_ADDR)
    else $error("no idle cycle after the column");

  idle_addr_a: assert property (@(posedge mclk) disable iff (reset)
    !row_phase && !col_phase |-> mem_addr == `IDLE_ADDR)
    else $error("address lines not parked while idle");

  self_run_a: assert property (@(posedge mclk) disable iff (reset)
    f_valid && f_ready |=> row_phase ##1 col_phase ##1 !row_phase && !col_phase)
    else $error("sequence did not run unaided");

  head_taken_a: assert property (@(posedge mclk) disable iff (reset)
    f_valid && !row_phase && !col_phase |=> row_phase)
    else $error("queued request not started while idle");

  ready_after_col_a: assert property (@(posedge mclk) disable iff (reset)
    col_phase |=> f_ready)
    else $error("sequencer not free after the column");

  full_holds_a: assert property (@(posedge mclk) disable iff (reset)
    !req_ready |-> f_valid)
    else $error("request port refused with nothing queued");

  // Address lines
  row_full_a: assert property (@(posedge mclk) disable iff (reset)
    f_valid && f_ready |=> mem_addr == $past(f_row))
    else $error("row address not on all twelve lines");

  row_addr_a: assert property (@(posedge mclk) disable iff (reset)
    row_phase |-> mem_addr == $past(f_row))
    else $error("row phase shows a wrong row");

  col_lines_a: assert property (@(posedge mclk) disable iff (reset)
    f_valid && f_ready |=> ##1
    {mem_addr[11], mem_addr[9:0]} == $past(f_col, 2))
    else $error("column address lines wrong");

  read_col_a: assert property (@(posedge mclk) disable iff (reset)
    f_valid && f_ready && !f_write |=> ##1
    col_phase && {mem_addr[11], mem_addr[9:0]} == $past(f_col, 2))
    else $error("read column address lines wrong");

  ap_line_a: assert property (@(posedge mclk) disable iff (reset)
    f_valid && f_ready |=> ##1 mem_addr[`AP_LINE] == $past(f_ap, 2))
    else $error("auto-precharge line wrong");

  ap_read_a: assert property (@(posedge mclk) disable iff (reset)
    f_valid && f_ready && !f_write |=> ##1
    mem_addr[`AP_LINE] == $past(f_ap, 2))
    else $error("auto-precharge line wrong on a read");

  // Byte mask and write data
  mask_write_a: assert property (@(posedge mclk) disable iff (reset)
    f_valid && f_ready && f_write |=> ##1 mem_byte_write_enable == $past(f_lanes, 2))
    else $error("byte mask does not match requested lanes");

  mask_read_a: assert property (@(posedge mclk) disable iff (reset)
    !col_phase |-> mem_byte_write_enable == 4'h0)
    else $error("mask high outside a write column");

  read_quiet_a: assert property (@(posedge mclk) disable iff (reset)
    f_valid && f_ready && !f_write |=> ##1
    mem_data_bus_oe_n && mem_byte_write_enable == `IDLE_MASK)
    else $error("read access drove mask or data");

  read_col_mask_a: assert property (@(posedge mclk) disable iff (reset)
    col_phase && mem_data_bus_oe_n |-> mem_byte_write_enable == `IDLE_MASK)
    else $error("mask high in a read column");

  lane_low_a: assert property (@(posedge mclk) disable iff (reset)
    f_valid && f_ready && f_write |=> ##1
    mem_byte_write_enable[0] == $past(f_lanes[0], 2) &&
    mem_data_bus_out[7:0] == $past(f_wdata[7:0], 2))
    else $error("lane 0 mask or data misplaced");

  lane_one_a: assert property (@(posedge mclk) disable iff (reset)
    f_valid && f_ready && f_write |=> ##1
    mem_byte_write_enable[1] == $past(f_lanes[1], 2) &&
    mem_data_bus_out[15:8] == $past(f_wdata[15:8], 2))
    else $error("lane 1 mask or data misplaced");

  lane_two_a: assert property (@(posedge mclk) disable iff (reset)
    f_valid && f_ready && f_write |=> ##1
    mem_byte_write_enable[2] == $past(f_lanes[2], 2) &&
    mem_data_bus_out[23:16] == $past(f_wdata[23:16], 2))
    else $error("lane 2 mask or data misplaced");

  lane_high_a: assert property (@(posedge mclk) disable iff (reset)
    f_valid && f_ready && f_write |=> ##1
    mem_byte_write_enable[3] == $past(f_lanes[3], 2) &&
    mem_data_bus_out[31:24] == $past(f_wdata[31:24], 2))
    else $error("lane 3 mask or data misplaced");

  mask_with_data_a: assert property (@(posedge mclk) disable iff (reset)
    mem_byte_write_enable != 4'h0 |-> !mem_data_bus_oe_n && col_phase)
    else $error("mask without write data");

  row_quiet_a: assert property (@(posedge mclk) disable iff (reset)
    row_phase |-> mem_byte_write_enable == `IDLE_MASK && mem_data_bus_oe_n)
    else $error("mask or data driven in the row phase");

  idle_quiet_a: assert property (@(posedge mclk) disable iff (reset)
    !row_phase && !col_phase |-> mem_byte_write_enable == `IDLE_MASK && mem_data_bus_oe_n)
    else $error("mask or data driven while idle");

  drive_in_col_a: assert property (@(posedge mclk) disable iff (reset)
    !mem_data_bus_oe_n |-> col_phase)
    else $error("data bus driven outside the column phase");

  write_drive_a: assert property (@(posedge mclk) disable iff (reset)
    f_valid && f_ready && f_write |=> ##1 !mem_data_bus_oe_n && col_phase)
    else $error("write data not driven with the column");

  data_word_a: assert property (@(posedge mclk) disable iff (reset)
    f_valid && f_ready && f_write |=> ##1 mem_data_bus_out == $past(f_wdata, 2))
    else $error("write data word wrong in the column phase");
endmodule

// ---- testbench/sdram_model.sv ----
// Far-side buffer memory model: latches row and column, merges written bytes.
// Assumes controller pins settle after a rising edge; read on the next one.
`timescale 1ns/1ps
module sdram_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Pins from the controller
  input wire logic [11:0] mem_addr,
  input wire logic [3:0] mem_byte_write_enable,
  input wire logic [31:0] mem_data_bus_out,
  input wire logic mem_data_bus_oe_n,
  input wire logic row_phase,
  input wire logic col_phase,
  // Captured view
  output logic [11:0] cap_row,
  output logic [10:0] cap_col,
  output logic cap_ap,
  output logic [3:0] cap_mask,
  output logic cap_oe_n,
  output logic [31:0] word,
  output logic [7:0] n_cols,
  output logic order_err
);
  logic row_open;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      row_open <= 1'b0;
      n_cols <= 8'h00;
      order_err <= 1'b0;
      word <= 32'h0;
    end else if (row_phase) begin
      row_open <= 1'b1;
      cap_row <= mem_addr;
    end else if (col_phase) begin
      if (!row_open) order_err <= 1'b1;
      row_open <= 1'b0;
      n_cols <= n_cols + 8'h01;
      cap_col <= {mem_addr[11], mem_addr[9:0]};
      cap_ap <= mem_addr[10];
      cap_mask <= mem_byte_write_enable;
      cap_oe_n <= mem_data_bus_oe_n;
      for (int i = 0; i < 4; i++)
        if (mem_byte_write_enable[i] && !mem_data_bus_oe_n)
          word[8*i+:8] <= mem_data_bus_out[8*i+:8];
    end
  end
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the memory address and byte-mask drive.
// Assumes the far-side memory model; no software setup is ever applied.
`timescale 1ns/1ps
module testbench;
  import mem_drive_pkg::*;
  logic mclk, reset, req_valid, req_ready, req_write, req_ap, oe_n, rp, cp;
  logic [11:0] req_row, mem_addr, cap_row;
  logic [10:0] req_col, cap_col;
  logic [3:0] lanes, bwe, cap_mask;
  logic [31:0] wdata, dout, word;
  logic [7:0] n_cols;
  logic cap_ap, cap_oe_n, order_err;
  int failures, n_tests;
  mem_addr_drive dut_u (.mclk(mclk), .reset(reset), .req_valid(req_valid),
    .req_ready(req_ready), .req_row(req_row), .req_col(req_col), .req_write(req_write),
    .req_auto_precharge(req_ap), .req_lane_write(lanes), .req_wdata(wdata),
    .mem_addr(mem_addr), .mem_byte_write_enable(bwe), .mem_data_bus_out(dout),
    .mem_data_bus_oe_n(oe_n), .row_phase(rp), .col_phase(cp));
  sdram_model mem_u (.mclk(mclk), .reset(reset), .mem_addr(mem_addr),
    .mem_byte_write_enable(bwe), .mem_data_bus_out(dout), .mem_data_bus_oe_n(oe_n),
    .row_phase(rp), .col_phase(cp), .cap_row(cap_row), .cap_col(cap_col),
    .cap_ap(cap_ap), .cap_mask(cap_mask), .cap_oe_n(cap_oe_n), .word(word),
    .n_cols(n_cols), .order_err(order_err));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task push(input logic [11:0] r, input logic [10:0] c, input logic w, input logic ap,
            input logic [3:0] m, input logic [31:0] d, output logic ok);
    @(negedge mclk);
    {req_valid, req_row, req_col, req_write, req_ap, lanes, wdata} = {1'b1, r, c, w, ap, m, d};
    ok = req_ready;
  endtask
  task wait_cols(input logic [7:0] n);
    @(negedge mclk);
    req_valid = 1'b0;
    for (int k = 0; k < 60 && n_cols !== n; k++) @(negedge mclk);
    if (n_cols !== n) begin
      failures++;
      $display("CHECK FAILED access count expected %h seen %h", n, n_cols);
      end_of_test;
    end
  endtask
  task t_write(input logic [3:0] m, input logic w);
    logic [31:0] d, e;
    logic [7:0] c;
    logic ok;
    d = 32'hc3a51e00 | {28'h0, m};
    e = word;
    c = n_cols;
    if (w) for (int i = 0; i < 4; i++) if (m[i]) e[8*i+:8] = d[8*i+:8];
    push(12'ha50 | {8'h0, m}, {m[0], 10'h2b3}, w, m[1], m, d, ok);
    wait_cols(c + 8'h01);
    chk("row", {20'h0, 12'ha50 | {8'h0, m}}, {20'h0, cap_row});
    chk("col", {21'h0, m[0], 10'h2b3}, {21'h0, cap_col});
    chk("precharge", {31'h0, m[1]}, {31'h0, cap_ap});
    chk("mask", {28'h0, w ? m : 4'h0}, {28'h0, cap_mask});
    chk("drive_n", {31'h0, !w}, {31'h0, cap_oe_n});
    chk("word", e, word);
  endtask
  task t_fill;
    logic [7:0] c, acc;
    logic ok;
    c = n_cols;
    acc = 8'h00;
    ok = 1'b1;
    for (int k = 0; k < 12 && ok; k++) begin
      push(12'h3c3, 11'h7ff, 1'b0, 1'b1, 4'hf, 32'h0, ok);
      if (ok) acc++;
    end
    chk("refused", 32'h0, {31'h0, ok});
    chk("accepted", 32'h6, {24'h0, acc});
    wait_cols(c + acc);
    chk("ready", 32'h1, {31'h0, req_ready});
  endtask
  task t_reset;
    reset = 1'b1;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    chk("idle addr", 32'h0, {20'h0, mem_addr});
    chk("idle ready", 32'h1, {31'h0, req_ready});
    chk("idle mask", 32'h0, {28'h0, bwe});
    chk("idle drive_n", 32'h1, {31'h0, oe_n});
    chk("idle phase", 32'h0, {30'h0, rp, cp});
  endtask
  initial begin
    {req_valid, req_row, req_col, req_write, req_ap, lanes, wdata} = '0;
    failures = 0;
    n_tests = 0;
    t_reset;
    for (int j = 0; j < 16; j++) t_write(j[3:0], 1'b1);
    t_write(4'hf, 1'b0);
    t_fill;
    chk("order", 32'h0, {31'h0, order_err});
    chk("rest addr", 32'h0, {20'h0, mem_addr});
    t_reset;
    t_write(4'ha, 1'b1);
    end_of_test;
  end
endmodule
